// >>> hdl/tkd_top.sv
// Eight-channel capacitive touch detection with register port and interrupt
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "tkd_params.svh"

module tkd_top
    import tkd_pkg::*;
#(
    parameter int NKEY = 8,
    parameter int LVL_W = 8
) (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic CE,
    input wire logic [`TKD_ADDR_W-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic SAMPLE_VALID,
    input wire logic [$clog2(NKEY)-1:0] SAMPLE_KEY,
    input wire logic [LVL_W-1:0] SAMPLE_LEVEL,
    output logic [NKEY-1:0] KEY_PRESSED,
    output logic [NKEY-1:0] KEY_NOISE,
    output logic [NKEY-1:0] CAL_BUSY,
    output logic SLEEP,
    output logic IRQ
);

    localparam int KW = $clog2(NKEY);

    tkd_key_cfg_t cfg_r [NKEY];
    logic [6:0] trig_th_r [NKEY];
    logic [6:0] noise_th_r;
    logic glob_int_en_r;
    logic sleep_r;
    logic [LVL_W-1:0] base_r [NKEY];
    logic [LVL_W-1:0] level_r [NKEY];
    logic [NKEY-1:0] cal_pend_r;
    logic [NKEY-1:0] pressed_r;
    logic [NKEY-1:0] noise_r;
    logic [NKEY-1:0] key_en_eff;
    logic [NKEY-1:0] int_en_eff;
    logic [NKEY:0] int_stat_r;
    logic [NKEY:0] int_mask_r;
    logic [NKEY:0] int_set;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    logic [KW-1:0] k_s;
    logic [LVL_W-1:0] diff_s;
    logic above_s;
    logic trig_s;
    logic noise_s;
    logic wake_ok_s;
    logic live_s;
    logic cal_s;
    logic wake_ev;

    function automatic logic slot_hit(input logic [`TKD_ADDR_W-1:0] addr, input logic [`TKD_ADDR_W-1:0] base);
        logic [`TKD_ADDR_W-1:0] off;
        off = addr - base;
        slot_hit = (addr >= base) && (off[1:0] == 2'h0) && (int'(off[`TKD_ADDR_W-1:2]) < NKEY);
    endfunction

    function automatic logic [KW-1:0] slot_idx(input logic [`TKD_ADDR_W-1:0] addr,
                                               input logic [`TKD_ADDR_W-1:0] base);
        logic [`TKD_ADDR_W-1:0] off;
        off = addr - base;
        slot_idx = off[KW+1:2];
    endfunction

    // Deviation either way, so a dip below baseline can still read as noise
    function automatic logic [LVL_W-1:0] abs_diff(input logic [LVL_W-1:0] a, input logic [LVL_W-1:0] b);
        abs_diff = (a > b) ? a - b : b - a;
    endfunction

    // Pin function overrides the enables software wrote; the raw bits are kept
    always_comb begin
        for (int k = 0; k < NKEY; k++) begin
            key_en_eff[k] = cfg_r[k].key_en;
            int_en_eff[k] = cfg_r[k].int_en;
            case (cfg_r[k].fn)
                PF_GPIO_HI, PF_GPIO_LO: begin
                    key_en_eff[k] = 1'b0;
                end
                PF_SHIELD, PF_INT_OUT, PF_BUZZER, PF_POWER: begin
                    int_en_eff[k] = 1'b0;
                end
                default: begin
                    key_en_eff[k] = cfg_r[k].key_en;
                end
            endcase
        end
    end

    // Evaluation of the sample arriving this cycle against its own key
    always_comb begin
        k_s = SAMPLE_KEY;
        above_s = SAMPLE_LEVEL > base_r[k_s];
        diff_s = abs_diff(SAMPLE_LEVEL, base_r[k_s]);
        trig_s = above_s && (diff_s > LVL_W'(trig_th_r[k_s]));
        noise_s = (diff_s > LVL_W'(noise_th_r)) && !trig_s;
        wake_ok_s = key_en_eff[k_s] && cfg_r[k_s].wake_en && (cfg_r[k_s].fn == PF_TOUCH);
        live_s = key_en_eff[k_s] && (!sleep_r || wake_ok_s);
        cal_s = cal_pend_r[k_s];
        wake_ev = SAMPLE_VALID && sleep_r && wake_ok_s && !cal_s && trig_s;
        int_set = '0;
        if (SAMPLE_VALID && live_s && !cal_s && trig_s && !pressed_r[k_s] &&
            int_en_eff[k_s] && glob_int_en_r) begin
            int_set[k_s] = 1'b1;
        end
        int_set[NKEY] = wake_ev;
    end

    // Per-key configuration and pin function
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            for (int k = 0; k < NKEY; k++) begin
                cfg_r[k] <= '{key_en: `TKD_KEY_EN_RST, int_en: `TKD_INT_EN_RST,
                              wake_en: `TKD_WAKE_EN_RST, fn: PF_TOUCH};
            end
        end else if (CE && WR) begin
            for (int k = 0; k < NKEY; k++) begin
                case (ADDR)
                    `TKD_KEY_EN_OFS: cfg_r[k].key_en <= WDATA[k];
                    `TKD_KEY_INT_EN_OFS: cfg_r[k].int_en <= WDATA[k];
                    `TKD_WAKE_EN_OFS: cfg_r[k].wake_en <= WDATA[k];
                    `TKD_PIN_FN_OFS: cfg_r[k].fn <= tkd_pin_fn_t'(WDATA[`TKD_PIN_FN_W*k +: `TKD_PIN_FN_W]);
                    default: cfg_r[k] <= cfg_r[k];
                endcase
            end
        end
    end

    // Thresholds, full 7-bit range taken as written
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            for (int k = 0; k < NKEY; k++) begin
                trig_th_r[k] <= `TKD_TRIG_TH_RST;
            end
            noise_th_r <= `TKD_NOISE_TH_RST;
        end else if (CE && WR) begin
            if (slot_hit(ADDR, `TKD_TRIG_TH_OFS)) begin
                trig_th_r[slot_idx(ADDR, `TKD_TRIG_TH_OFS)] <= WDATA[6:0];
            end
            if (ADDR == `TKD_NOISE_TH_OFS) begin
                noise_th_r <= WDATA[6:0];
            end
        end
    end

    // Global interrupt enable and sleep; a wake beats a concurrent sleep write
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            glob_int_en_r <= 1'b0;
            sleep_r <= 1'b0;
        end else if (CE) begin
            if (WR && ADDR == `TKD_CTRL_OFS) begin
                glob_int_en_r <= WDATA[`TKD_CTRL_GIE_BIT];
            end
            if (wake_ev) begin
                sleep_r <= 1'b0;
            end else if (WR && ADDR == `TKD_CTRL_OFS) begin
                sleep_r <= WDATA[`TKD_CTRL_SLEEP_BIT];
            end
        end
    end

    // Recalibration requests; every key calibrates once after reset.
    // Result is only sound if nobody touches the pad meanwhile.
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            cal_pend_r <= '1;
        end else if (CE) begin
            for (int k = 0; k < NKEY; k++) begin
                if (WR && ADDR == `TKD_CAL_OFS && WDATA[k]) begin
                    cal_pend_r[k] <= 1'b1;
                end else if (SAMPLE_VALID && int'(k_s) == k) begin
                    cal_pend_r[k] <= 1'b0;
                end
            end
        end
    end

    // Latest level per key and baseline capture
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            for (int k = 0; k < NKEY; k++) begin
                base_r[k] <= '0;
                level_r[k] <= '0;
            end
        end else if (CE && SAMPLE_VALID) begin
            level_r[k_s] <= SAMPLE_LEVEL;
            if (cal_s) begin
                base_r[k_s] <= SAMPLE_LEVEL;
            end
        end
    end

    // Touch and noise state, updated each time the key is sampled
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            pressed_r <= '0;
            noise_r <= '0;
        end else if (CE) begin
            if (SAMPLE_VALID) begin
                if (cal_s || !live_s) begin
                    pressed_r[k_s] <= 1'b0;
                    noise_r[k_s] <= 1'b0;
                end else begin
                    pressed_r[k_s] <= trig_s;
                    noise_r[k_s] <= noise_s;
                end
            end
            // A disabled key drops its state at once, not at its next sample
            for (int k = 0; k < NKEY; k++) begin
                if (!key_en_eff[k]) begin
                    pressed_r[k] <= 1'b0;
                    noise_r[k] <= 1'b0;
                end
            end
        end
    end

    // Sticky interrupt status, write one to clear; a new event beats the clear
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            int_stat_r <= '0;
            int_mask_r <= '0;
        end else if (CE) begin
            if (WR && ADDR == `TKD_INT_STAT_OFS) begin
                int_stat_r <= (int_stat_r & ~WDATA[NKEY:0]) | int_set;
            end else begin
                int_stat_r <= int_stat_r | int_set;
            end
            if (WR && ADDR == `TKD_INT_MASK_OFS) begin
                int_mask_r <= WDATA[NKEY:0];
            end
        end
    end

    // Read mux; key enable views show the effective, pin-forced value
    always_comb begin
        rdata_nxt = '0;
        case (ADDR)
            `TKD_CTRL_OFS: begin
                rdata_nxt[`TKD_CTRL_GIE_BIT] = glob_int_en_r;
                rdata_nxt[`TKD_CTRL_SLEEP_BIT] = sleep_r;
            end
            `TKD_KEY_EN_OFS: rdata_nxt[NKEY-1:0] = key_en_eff;
            `TKD_KEY_INT_EN_OFS: rdata_nxt[NKEY-1:0] = int_en_eff;
            `TKD_WAKE_EN_OFS: begin
                for (int k = 0; k < NKEY; k++) begin
                    rdata_nxt[k] = cfg_r[k].wake_en;
                end
            end
            `TKD_CAL_OFS: rdata_nxt[NKEY-1:0] = cal_pend_r;
            `TKD_NOISE_TH_OFS: rdata_nxt[6:0] = noise_th_r;
            `TKD_PRESS_OFS: rdata_nxt[NKEY-1:0] = pressed_r;
            `TKD_NOISE_OFS: rdata_nxt[NKEY-1:0] = noise_r;
            `TKD_INT_STAT_OFS: rdata_nxt[NKEY:0] = int_stat_r;
            `TKD_INT_MASK_OFS: rdata_nxt[NKEY:0] = int_mask_r;
            `TKD_PIN_FN_OFS: begin
                for (int k = 0; k < NKEY; k++) begin
                    rdata_nxt[`TKD_PIN_FN_W*k +: `TKD_PIN_FN_W] = cfg_r[k].fn;
                end
            end
            default: begin
                if (slot_hit(ADDR, `TKD_TRIG_TH_OFS)) begin
                    rdata_nxt[6:0] = trig_th_r[slot_idx(ADDR, `TKD_TRIG_TH_OFS)];
                end else if (slot_hit(ADDR, `TKD_LEVEL_OFS)) begin
                    rdata_nxt[LVL_W-1:0] = level_r[slot_idx(ADDR, `TKD_LEVEL_OFS)];
                    rdata_nxt[`TKD_LEVEL_BASE_LSB +: LVL_W] = base_r[slot_idx(ADDR, `TKD_LEVEL_OFS)];
                end
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe, zero otherwise
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            rdata_r <= '0;
        end else if (CE) begin
            if (RD) begin
                rdata_r <= rdata_nxt;
            end else begin
                rdata_r <= 32'h0000_0000;
            end
        end
    end

    assign RDATA = rdata_r;
    assign KEY_PRESSED = pressed_r;
    assign KEY_NOISE = noise_r;
    assign CAL_BUSY = cal_pend_r;
    assign SLEEP = sleep_r;
    // Level interrupt; stays up until software clears the status bit or its mask bit
    assign IRQ = |(int_stat_r & int_mask_r);

endmodule

`default_nettype wire

// >>> shared/tkd_params.svh
// Register map, field positions and reset values of the touch key detector
// Function
// - Per-key 7-bit trigger threshold, key zero at 0x30
// - Trigger thresholds accept zero through 127
// - Key triggers when level rises above threshold
// - Current sensed level readable for each key
// - Disabled key ignores touches, others unaffected
// - GPIO-driven key pin forces key enable off
// - Global interrupt enable gates every key interrupt
// - Shield/buzzer/INT/power pin clears key interrupt enable
// - Commanded forced recalibration of a single key
// - Eight per-key noise indicators, high while noisy
// - Programmable noise threshold from zero to 127
// - Change above noise, not trigger, flags noise
// - Sleep wakes only via touch key with wake
`ifndef TKD_PARAMS_SVH
`define TKD_PARAMS_SVH

`define TKD_ADDR_W 8
`define TKD_CTRL_OFS 8'h00
`define TKD_KEY_EN_OFS 8'h04
`define TKD_KEY_INT_EN_OFS 8'h08
`define TKD_WAKE_EN_OFS 8'h0C
`define TKD_CAL_OFS 8'h10
`define TKD_NOISE_TH_OFS 8'h14
`define TKD_PRESS_OFS 8'h18
`define TKD_NOISE_OFS 8'h1C
`define TKD_INT_STAT_OFS 8'h20
`define TKD_INT_MASK_OFS 8'h24
`define TKD_PIN_FN_OFS 8'h28
`define TKD_TRIG_TH_OFS 8'h30
`define TKD_LEVEL_OFS 8'h50

`define TKD_CTRL_GIE_BIT 0
`define TKD_CTRL_SLEEP_BIT 1
`define TKD_PIN_FN_W 3
`define TKD_LEVEL_BASE_LSB 16

`define TKD_TRIG_TH_RST 7'h0F
`define TKD_NOISE_TH_RST 7'h08
`define TKD_KEY_EN_RST 1'b1
`define TKD_INT_EN_RST 1'b0
`define TKD_WAKE_EN_RST 1'b0

`endif

// >>> shared/tkd_pkg.sv
// Types shared by the touch key detector
`default_nettype none

package tkd_pkg;

    typedef enum logic [2:0] {
        PF_TOUCH = 3'h0,
        PF_GPIO_HI = 3'h1,
        PF_GPIO_LO = 3'h2,
        PF_SHIELD = 3'h3,
        PF_INT_OUT = 3'h4,
        PF_BUZZER = 3'h5,
        PF_POWER = 3'h6,
        PF_SPARE = 3'h7
    } tkd_pin_fn_t;

    typedef struct packed {
        logic key_en;
        logic int_en;
        logic wake_en;
        tkd_pin_fn_t fn;
    } tkd_key_cfg_t;

endpackage

`default_nettype wire

// >>> test/tkd_pad_model.sv
// Behavioural touch pads handing sensed levels to the detector
`timescale 1ns/100ps
`default_nettype none

module tkd_pad_model (
    input wire logic clk,
    output logic valid,
    output logic [2:0] key,
    output logic [7:0] level
);
    initial begin
        valid = 1'b0;
        key = 3'h0;
        level = 8'h0;
    end

    // Lines change when idle so a stale level is never mistaken for a sample
    task automatic touch(input logic [2:0] k, input logic [7:0] l);
        @(posedge clk);
        valid <= 1'b1;
        key <= k;
        level <= l;
        @(posedge clk);
        valid <= 1'b0;
        key <= ~k;
        level <= ~l;
    endtask
endmodule

`default_nettype wire

// >>> test/tkd_props.sv
// Port checker for the touch key detector
`timescale 1ns/100ps
`default_nettype none
`include "tkd_params.svh"

module tkd_props
    import tkd_pkg::*;
#(
    parameter int NKEY = 8,
    parameter int LVL_W = 8
) (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic CE,
    input wire logic [`TKD_ADDR_W-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic SAMPLE_VALID,
    input wire logic [$clog2(NKEY)-1:0] SAMPLE_KEY,
    input wire logic [LVL_W-1:0] SAMPLE_LEVEL,
    input wire logic [NKEY-1:0] KEY_PRESSED,
    input wire logic [NKEY-1:0] KEY_NOISE,
    input wire logic [NKEY-1:0] CAL_BUSY,
    input wire logic SLEEP,
    input wire logic IRQ
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);

    sequence s_cal_take;
        CE && SAMPLE_VALID && CAL_BUSY[SAMPLE_KEY] && !WR;
    endsequence
    property p_cal_take;
        s_cal_take |=> !CAL_BUSY[$past(SAMPLE_KEY)] && !KEY_PRESSED[$past(SAMPLE_KEY)] &&
            !KEY_NOISE[$past(SAMPLE_KEY)];
    endproperty
    property p_rst;
        disable iff (1'b0) SRST && CE |=> KEY_PRESSED == '0 && KEY_NOISE == '0 && CAL_BUSY == '1 && !IRQ;
    endproperty
    property p_rd_zero;
        CE && !RD |=> RDATA == 32'h0;
    endproperty
    property p_excl;
        (KEY_PRESSED & KEY_NOISE) == '0;
    endproperty
    property p_cal_cmd;
        CE && WR && ADDR == `TKD_CAL_OFS |=> (CAL_BUSY & $past(WDATA[NKEY-1:0])) == $past(WDATA[NKEY-1:0]);
    endproperty
    property p_hold;
        CE && !SAMPLE_VALID && !WR |=> $stable(KEY_PRESSED) && $stable(KEY_NOISE);
    endproperty
    property p_wake;
        $fell(SLEEP) |-> $past(CE && (SAMPLE_VALID || WR));
    endproperty
    property p_press_src;
        (KEY_PRESSED & ~$past(KEY_PRESSED)) != '0 |-> $past(SAMPLE_VALID);
    endproperty

    a_cal_take: assert property (p_cal_take) else $error("calibrating sample left key busy or flagged");
    a_rst: assert property (p_rst) else $error("outputs wrong under reset");
    a_rd_zero: assert property (p_rd_zero) else $error("read data outside read slot");
    a_excl: assert property (p_excl) else $error("key both pressed and noisy");
    a_cal_cmd: assert property (p_cal_cmd) else $error("recalibrate command not pending");
    a_hold: assert property (p_hold) else $error("key state moved with no cause");
    a_wake: assert property (p_wake) else $error("sleep left with no cause");
    a_press_src: assert property (p_press_src) else $error("press with no sample");
endmodule

bind tkd_top tkd_props #(.NKEY(NKEY), .LVL_W(LVL_W)) tkd_props_inst (.*);

`default_nettype wire

// >>> test/tkd_top_tb.sv
// Self-checking bench for the touch key detector
`timescale 1ns/100ps
`default_nettype none

module tkd_top_tb;
    logic MCLK = 1'b0, SRST = 1'b1, CE = 1'b1, WR = 1'b0, RD = 1'b0;
    logic [7:0] ADDR = 8'h0;
    logic [31:0] WDATA = 32'h0, RDATA;
    logic sv;
    logic [2:0] sk;
    logic [7:0] sl, KEY_PRESSED, KEY_NOISE, CAL_BUSY;
    logic SLEEP, IRQ;
    int failures = 0, comparisons = 0;

    always #4 MCLK = ~MCLK;

    tkd_pad_model pad_inst (.clk(MCLK), .valid(sv), .key(sk), .level(sl));
    tkd_top tkd_top_inst (.MCLK(MCLK), .SRST(SRST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .SAMPLE_VALID(sv), .SAMPLE_KEY(sk), .SAMPLE_LEVEL(sl), .KEY_PRESSED(KEY_PRESSED),
        .KEY_NOISE(KEY_NOISE), .CAL_BUSY(CAL_BUSY), .SLEEP(SLEEP), .IRQ(IRQ));

    task chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge MCLK);
        WR <= 1'b0;
        #1;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge MCLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge MCLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask
    task rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(d, e);
    endtask
    task tch(input logic [2:0] k, input logic [7:0] l);
        pad_inst.touch(k, l);
        #1;
    endtask
    task final_report;
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task t_reset;
        rc(8'h30, 32'h0F);
        rc(8'h14, 32'h08);
        rc(8'h04, 32'hFF);
        rc(8'hFC, 32'h0);
        chk(32'(CAL_BUSY), 32'hFF);
        chk(32'(KEY_PRESSED | KEY_NOISE), 32'h0);
        chk(32'({SLEEP, IRQ}), 32'h0);
        $display("reset done");
    endtask
    task t_thresh;
        for (int k = 0; k < 8; k++) begin
            tch(k[2:0], 8'h40); // Pads idle while calibrating
        end
        chk(32'(CAL_BUSY), 32'h0);
        wr(8'h30, 32'hFF);
        rc(8'h30, 32'h7F);
        wr(8'h30, 32'h0);
        wr(8'h34, 32'h7F);
        tch(3'h0, 8'h41);
        chk(32'(KEY_PRESSED[0]), 32'h1);
        tch(3'h0, 8'h40);
        chk(32'(KEY_PRESSED[0]), 32'h0);
        tch(3'h1, 8'hBF);
        chk(32'({KEY_PRESSED[1], KEY_NOISE[1]}), 32'h1);
        tch(3'h1, 8'hC0);
        chk(32'({KEY_PRESSED[1], KEY_NOISE[1]}), 32'h2);
        rc(8'h54, 32'h0040_00C0);
        $display("threshold done");
    endtask
    task t_noise;
        tch(3'h2, 8'h49);
        chk(32'({KEY_PRESSED[2], KEY_NOISE[2]}), 32'h1);
        tch(3'h2, 8'h48);
        chk(32'(KEY_NOISE[2]), 32'h0);
        tch(3'h2, 8'h37);
        chk(32'(KEY_NOISE[2]), 32'h1);
        rc(8'h1C, 32'h04);
        rc(8'h18, 32'h02);
        $display("noise done");
    endtask
    task t_enable;
        logic [31:0] d;
        wr(8'h04, 32'hF7);
        tch(3'h3, 8'h80);
        chk(32'(KEY_PRESSED[3]), 32'h0);
        tch(3'h4, 8'h80);
        chk(32'(KEY_PRESSED[4]), 32'h1);
        wr(8'h04, 32'hFF);
        wr(8'h00, 32'h1); // Global enable first
        wr(8'h08, 32'hFF);
        for (int f = 1; f < 8; f++) begin
            wr(8'h28, f << 18);
            rc(8'h28, f << 18);
            rd(8'h04, d);
            chk(32'(d[6]), 32'(f != 1 && f != 2));
            rd(8'h08, d);
            chk(32'(d[6]), 32'(f < 3 || f > 6));
        end
        wr(8'h28, 32'h0);
        $display("enable done");
    endtask
    task t_irq;
        wr(8'h24, 32'h1FF);
        wr(8'h20, 32'h1FF);
        tch(3'h7, 8'h60);
        chk(32'(IRQ), 32'h1);
        wr(8'h20, 32'h80);
        chk(32'(IRQ), 32'h0);
        tch(3'h7, 8'h40);
        wr(8'h24, 32'h0);
        tch(3'h7, 8'h60);
        chk(32'(IRQ), 32'h0);
        rc(8'h20, 32'h80);
        wr(8'h20, 32'h80);
        tch(3'h7, 8'h40);
        wr(8'h24, 32'h1FF);
        wr(8'h00, 32'h0);
        tch(3'h7, 8'h60);
        chk(32'(IRQ), 32'h0);
        rc(8'h20, 32'h0);
        $display("interrupt done");
    endtask
    task t_cal;
        wr(8'h10, 32'h04);
        chk(32'(CAL_BUSY[2]), 32'h1);
        tch(3'h2, 8'h50);
        chk(32'(CAL_BUSY[2]), 32'h0); // Untouched level
        rc(8'h58, 32'h0050_0050);
        tch(3'h2, 8'h60);
        chk(32'(KEY_PRESSED[2]), 32'h1);
        $display("calibration done");
    endtask
    task t_sleep;
        wr(8'h00, 32'h2);
        chk(32'(SLEEP), 32'h1);
        wr(8'h0C, 32'h1);
        tch(3'h1, 8'hC0);
        chk(32'({SLEEP, KEY_PRESSED[1]}), 32'h2);
        tch(3'h0, 8'h42);
        chk(32'(SLEEP), 32'h0);
        rc(8'h20, 32'h100);
        $display("sleep done");
    endtask
    task t_freeze;
        @(posedge MCLK);
        CE <= 1'b0;
        tch(3'h5, 8'h80);
        chk(32'(KEY_PRESSED[5]), 32'h0);
        wr(8'h14, 32'h7F);
        @(posedge MCLK);
        CE <= 1'b1;
        rc(8'h14, 32'h08);
        tch(3'h5, 8'h80);
        chk(32'(KEY_PRESSED[5]), 32'h1);
        $display("freeze done");
    endtask

    initial begin
        repeat (6) @(posedge MCLK);
        SRST <= 1'b0;
        t_reset;
        t_thresh;
        t_noise;
        t_enable;
        t_irq;
        t_cal;
        t_sleep;
        t_freeze;
        final_report;
    end

    // Whole run needs about two hundred cycles; reaching the 25000-cycle limit means a hang
    initial begin
        #200000;
        failures++;
        final_report;
    end
endmodule

`default_nettype wire
